// ===== pkg/srd_pkg.sv
// Constants, types and field layout for the link PLL control register bank
// Functional notes
// RULE1: Equalizer power field bits 7:6, 00 normal, 01 low power, resets to 01.
// RULE2: Recalibrate trigger rising from zero to one reruns all PLL calibrations.
// RULE3: Only the rising edge acts; software clears it before another recalibration.
// RULE4: Setting power-up turns on PLL bias currents, then starts calibration automatically.
// RULE5: Software provides reference clock and correct predivider before setting power-up.
// RULE6: Read-only flag is one while charge pump output is above range.
// RULE7: Read-only flag is one while charge pump output is below range.
// RULE8: Read-only flag is one when charge pump calibration finished and valid.
// RULE9: Read-only lock flag is one when the link PLL is locked.
// RULE10: Predivide code 00 divides reference by four, for 6 to 12.5 Gbps.
// RULE11: Predivide code 01 divides reference by two, for 3 to 6 Gbps.
// RULE12: Predivide code 10 is the setting for 1.5 to 3 Gbps.
// RULE13: Software keeps divided reference between 35 and 80 MHz.
// RULE14: First-group termination trigger rising edge launches termination calibration.
// RULE15: Predivide code 10 passes the reference through undivided.
// RULE16: Triggers edge-detected against previous value; status reads never clear flags.
package srd_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [14:0] SRD_ADDR_EQ_BIAS   = 15'h0268;
  localparam logic [14:0] SRD_ADDR_PLL_EN    = 15'h0280;
  localparam logic [14:0] SRD_ADDR_PLL_STATE = 15'h0281;
  localparam logic [14:0] SRD_ADDR_PREDIV    = 15'h0289;
  localparam logic [14:0] SRD_ADDR_TERM_CAL1 = 15'h02A7;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          SRD_EQ_PWR_LSB     = 6;
  localparam logic [7:0]  SRD_EQ_BIAS_RST    = 8'h44;  // Low power code plus reserved 0x4
  localparam int          SRD_EN_RECAL_BIT   = 2;
  localparam int          SRD_EN_RSVD_BIT    = 1;
  localparam int          SRD_EN_PWR_BIT     = 0;
  localparam logic [2:0]  SRD_EN_RST         = 3'h0;
  localparam int          SRD_ST_ABOVE_BIT   = 5;
  localparam int          SRD_ST_BELOW_BIT   = 4;
  localparam int          SRD_ST_CALOK_BIT   = 3;
  localparam int          SRD_ST_LOCK_BIT    = 0;
  localparam logic [1:0]  SRD_PREDIV_RST     = 2'h0;
  localparam logic [1:0]  SRD_EQ_NORMAL      = 2'h0;
  localparam logic [1:0]  SRD_EQ_LOW_POWER   = 2'h1;

  // ****************************************************************
  // Predivide codes and ratios
  // ****************************************************************
  localparam logic [1:0]  SRD_PREDIV_BY4     = 2'h0;
  localparam logic [1:0]  SRD_PREDIV_BY2     = 2'h1;
  localparam logic [1:0]  SRD_PREDIV_BY1     = 2'h2;
  localparam logic [2:0]  SRD_RATIO_4        = 3'h4;
  localparam logic [2:0]  SRD_RATIO_2        = 3'h2;
  localparam logic [2:0]  SRD_RATIO_1        = 3'h1;

  // ****************************************************************
  // Serial port framing
  // ****************************************************************
  localparam logic [4:0]  SRD_INSTR_LAST     = 5'h0F;  // 16 instruction bits
  localparam logic [4:0]  SRD_DATA_LAST      = 5'h07;  // 8 data bits
  localparam logic [4:0]  SRD_DATA_DONE      = 5'h08;

  typedef enum logic [2:0] {
    SRD_SPI_IDLE  = 3'b001,
    SRD_SPI_INSTR = 3'b010,
    SRD_SPI_DATA  = 3'b100
  } srd_spi_state_type;

  // Analog status from the PLL
  typedef struct packed {
    logic above;
    logic below;
    logic cal_ok;
    logic locked;
  } srd_pll_stat_type;

  // Controls toward the PLL, equalizer and termination
  typedef struct packed {
    logic [1:0] equalizer_power_setting;
    logic       pll_bias_on;
    logic       pll_cal_start;
    logic       term_cal_start;
    logic [1:0] reference_predivide_select;
    logic [2:0] predivide_ratio;
  } srd_ctrl_type;

endpackage

// ===== rtl/srd_pll_regs.sv
// Link PLL control and status registers behind the serial configuration port
`timescale 1ns/1ps
module srd_pll_regs
  import srd_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             spi_sclk,
  input  wire logic             spi_cs_n,
  input  wire logic             spi_sdio_in,
  output logic                  spi_sdio_out,
  output logic                  spi_sdio_oe_n,
  input  wire srd_pll_stat_type pll_stat,
  output srd_ctrl_type          ctrl
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic             sclk_m_r, sclk_s_r, sclk_d_r;
  logic             cs_n_m_r, cs_n_s_r;
  logic             sdio_m_r, sdio_s_r;
  srd_pll_stat_type stat_m_r, stat_s_r;
  // Two flops on every pin, plus a third on sclk for edge detection; the first flop feeds only the second
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sclk_m_r <= 1'b0;
      sclk_s_r <= 1'b0;
      sclk_d_r <= 1'b0;
      cs_n_m_r <= 1'b1;
      cs_n_s_r <= 1'b1;
      sdio_m_r <= 1'b0;
      sdio_s_r <= 1'b0;
      stat_m_r <= '0;
      stat_s_r <= '0;
    end
    else if (clk_en)
    begin
      sclk_m_r <= spi_sclk;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      cs_n_m_r <= spi_cs_n;
      cs_n_s_r <= cs_n_m_r;
      sdio_m_r <= spi_sdio_in;
      sdio_s_r <= sdio_m_r;
      stat_m_r <= pll_stat;
      stat_s_r <= stat_m_r;
    end
  end

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s_r & ~sclk_d_r & ~cs_n_s_r;
  assign sclk_fall = ~sclk_s_r & sclk_d_r & ~cs_n_s_r;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0]  eq_bias_r;
  logic [2:0]  pll_en_r;
  logic [1:0]  prediv_r;
  logic        term_cal1_r;
  logic [7:0]  pll_state_r;
  logic        wr_stb_r;
  logic [14:0] wr_addr_r;
  logic [7:0]  wr_data_r;
  // Read view; status is rebuilt from live flags so a read never clears it
  function automatic logic [7:0] srd_read(input logic [14:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      SRD_ADDR_EQ_BIAS:   d = eq_bias_r;
      SRD_ADDR_PLL_EN:    d = {5'h00, pll_en_r};
      SRD_ADDR_PLL_STATE: d = pll_state_r;  // RULE16
      SRD_ADDR_PREDIV:    d = {6'h00, prediv_r};
      SRD_ADDR_TERM_CAL1: d = {7'h00, term_cal1_r};
      default:            d = 8'h00;        // Unmapped reads as zero
    endcase
    return d;
  endfunction

  // ****************************************************************
  // Serial port engine
  // ****************************************************************
  srd_spi_state_type state_r;
  logic [15:0]       shift_r;
  logic [4:0]        cnt_r;
  logic              rd_r;
  logic [14:0]       addr_r;
  logic [7:0]        rdata_r;
  logic              sdio_out_r;
  logic              sdio_oe_n_r;
  // Instruction: read flag then 15 address bits, MSB first; one data byte follows
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r     <= SRD_SPI_IDLE;
      shift_r     <= 16'h0000;
      cnt_r       <= 5'h00;
      rd_r        <= 1'b0;
      addr_r      <= 15'h0000;
      rdata_r     <= 8'h00;
      sdio_out_r  <= 1'b0;
      sdio_oe_n_r <= 1'b1;
      wr_stb_r    <= 1'b0;
      wr_addr_r   <= 15'h0000;
      wr_data_r   <= 8'h00;
    end
    else if (clk_en)
    begin
      wr_stb_r <= 1'b0;
      if (cs_n_s_r)
      begin
        state_r     <= SRD_SPI_IDLE;
        cnt_r       <= 5'h00;
        sdio_oe_n_r <= 1'b1;
      end
      else
      begin
        unique case (state_r)
          SRD_SPI_IDLE:  state_r <= SRD_SPI_INSTR;
          SRD_SPI_INSTR:
            if (sclk_rise)
            begin
              shift_r <= {shift_r[14:0], sdio_s_r};
              cnt_r   <= cnt_r + 5'h01;
              if (cnt_r == SRD_INSTR_LAST)
              begin
                rd_r    <= shift_r[14];
                addr_r  <= {shift_r[13:0], sdio_s_r};
                rdata_r <= srd_read({shift_r[13:0], sdio_s_r});
                cnt_r   <= 5'h00;
                state_r <= SRD_SPI_DATA;
              end
            end
          SRD_SPI_DATA:
          begin
            if (sclk_rise && cnt_r != SRD_DATA_DONE)
            begin
              shift_r <= {shift_r[14:0], sdio_s_r};
              cnt_r   <= cnt_r + 5'h01;
              // Write takes effect on the eighth data bit; extra bits ignored
              if (cnt_r == SRD_DATA_LAST && !rd_r)
              begin
                wr_stb_r  <= 1'b1;
                wr_addr_r <= addr_r;
                wr_data_r <= {shift_r[6:0], sdio_s_r};
              end
            end
            // Read data leaves on falling edges so the host samples on rising
            if (sclk_fall && rd_r)
            begin
              sdio_out_r  <= rdata_r[7];
              sdio_oe_n_r <= 1'b0;
              rdata_r     <= {rdata_r[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

  logic wr_eq, wr_en, wr_pd, wr_tc;
  assign wr_eq = wr_stb_r && wr_addr_r == SRD_ADDR_EQ_BIAS;
  assign wr_en = wr_stb_r && wr_addr_r == SRD_ADDR_PLL_EN;
  assign wr_pd = wr_stb_r && wr_addr_r == SRD_ADDR_PREDIV;
  assign wr_tc = wr_stb_r && wr_addr_r == SRD_ADDR_TERM_CAL1;

  // ****************************************************************
  // Software-written registers
  // ****************************************************************
  // Equalizer bias register, power field resets to low power
  always_ff @(posedge clock)
  begin
    if (reset)
      eq_bias_r <= SRD_EQ_BIAS_RST;  // RULE1
    else if (clk_en && wr_eq)
      eq_bias_r <= wr_data_r;        // RULE1
  end

  // PLL enable register: recalibrate, reserved and power-up bits
  always_ff @(posedge clock)
  begin
    if (reset)
      pll_en_r <= SRD_EN_RST;
    else if (clk_en && wr_en)
      pll_en_r <= wr_data_r[2:0];
  end

  // Predivider and termination trigger
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      prediv_r    <= SRD_PREDIV_RST;
      term_cal1_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_pd)
        prediv_r <= wr_data_r[1:0];
      if (wr_tc)
        term_cal1_r <= wr_data_r[0];
    end
  end

  // ****************************************************************
  // Status register
  // ****************************************************************
  // Live flags, refreshed every cycle; reading has no side effect
  always_ff @(posedge clock)
  begin
    if (reset)
      pll_state_r <= 8'h00;
    else if (clk_en)
    begin
      pll_state_r                   <= 8'h00;
      pll_state_r[SRD_ST_ABOVE_BIT] <= stat_s_r.above;   // RULE6
      pll_state_r[SRD_ST_BELOW_BIT] <= stat_s_r.below;   // RULE7
      pll_state_r[SRD_ST_CALOK_BIT] <= stat_s_r.cal_ok;  // RULE8
      pll_state_r[SRD_ST_LOCK_BIT]  <= stat_s_r.locked;  // RULE9
    end
  end

  // ****************************************************************
  // Trigger edges and outputs
  // ****************************************************************
  logic       recal_prev_r, term_prev_r, bias_prev_r;
  logic       bias_on_r, cal_start_r, term_start_r;
  logic [1:0] eq_pwr_r, prediv_out_r;
  logic [2:0] ratio_r;
  // Held trigger bits start nothing; software must lower them to rearm
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      recal_prev_r <= 1'b0;
      term_prev_r  <= 1'b0;
      bias_prev_r  <= 1'b0;
      bias_on_r    <= 1'b0;
      cal_start_r  <= 1'b0;
      term_start_r <= 1'b0;
    end
    else if (clk_en)
    begin
      recal_prev_r <= pll_en_r[SRD_EN_RECAL_BIT];                         // RULE16
      term_prev_r  <= term_cal1_r;                                        // RULE16
      bias_on_r    <= pll_en_r[SRD_EN_PWR_BIT];                           // RULE4
      bias_prev_r  <= bias_on_r;
      // Calibration follows bias turn-on by one cycle so currents settle first
      cal_start_r  <= (pll_en_r[SRD_EN_RECAL_BIT] & ~recal_prev_r)        // RULE2 RULE3
                    | (bias_on_r & ~bias_prev_r);                         // RULE4
      term_start_r <= term_cal1_r & ~term_prev_r;                         // RULE14
    end
  end

  // Registered copies of field outputs and decoded divide ratio
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      eq_pwr_r     <= SRD_EQ_LOW_POWER;
      prediv_out_r <= SRD_PREDIV_RST;
      ratio_r      <= SRD_RATIO_4;
    end
    else if (clk_en)
    begin
      eq_pwr_r     <= eq_bias_r[SRD_EQ_PWR_LSB +: 2];                      // RULE1
      prediv_out_r <= prediv_r;
      unique case (prediv_r)
        SRD_PREDIV_BY4: ratio_r <= SRD_RATIO_4;                           // RULE10
        SRD_PREDIV_BY2: ratio_r <= SRD_RATIO_2;                           // RULE11
        SRD_PREDIV_BY1: ratio_r <= SRD_RATIO_1;                           // RULE12 RULE15
        default:        ratio_r <= SRD_RATIO_1;  // Undefined code kept undivided
      endcase
    end
  end

  assign spi_sdio_out  = sdio_out_r;
  assign spi_sdio_oe_n = sdio_oe_n_r;
  assign ctrl = '{eq_pwr_r, bias_on_r, cal_start_r, term_start_r, prediv_out_r, ratio_r};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset || !clk_en);

  sequence s_bias_then_cal; bias_on_r ##1 cal_start_r; endsequence

  property p_eq_reset_low_power; $fell(reset) |-> eq_pwr_r == SRD_EQ_LOW_POWER; endproperty
  a_eq_reset_low_power: assert property (p_eq_reset_low_power) // RULE1
    else $error("Equalizer power not low power after reset");
  property p_recal_edge; $rose(pll_en_r[SRD_EN_RECAL_BIT]) |=> cal_start_r; endproperty
  a_recal_edge: assert property (p_recal_edge) // RULE2
    else $error("Recalibrate edge gave no calibration start");
  property p_recal_level_quiet;
    pll_en_r[SRD_EN_RECAL_BIT] && $past(pll_en_r[SRD_EN_RECAL_BIT])
      && !(bias_on_r && !bias_prev_r) |=> !cal_start_r;
  endproperty
  a_recal_level_quiet: assert property (p_recal_level_quiet) // RULE3
    else $error("Held recalibrate bit restarted calibration");
  property p_power_up_seq; $rose(pll_en_r[SRD_EN_PWR_BIT]) |=> s_bias_then_cal; endproperty
  a_power_up_seq: assert property (p_power_up_seq) // RULE4
    else $error("Power-up did not enable bias then calibrate");
  property p_above_flag; ##1 pll_state_r[SRD_ST_ABOVE_BIT] == $past(stat_s_r.above); endproperty
  a_above_flag: assert property (p_above_flag) // RULE6
    else $error("Above-range flag wrong");
  property p_below_flag; ##1 pll_state_r[SRD_ST_BELOW_BIT] == $past(stat_s_r.below); endproperty
  a_below_flag: assert property (p_below_flag) // RULE7
    else $error("Below-range flag wrong");
  property p_calok_flag; ##1 pll_state_r[SRD_ST_CALOK_BIT] == $past(stat_s_r.cal_ok); endproperty
  a_calok_flag: assert property (p_calok_flag) // RULE8
    else $error("Calibration valid flag wrong");
  property p_lock_flag; ##1 pll_state_r[SRD_ST_LOCK_BIT] == $past(stat_s_r.locked); endproperty
  a_lock_flag: assert property (p_lock_flag) // RULE9
    else $error("Lock flag does not follow the PLL");
  property p_ratio_by4; prediv_r == SRD_PREDIV_BY4 |=> ratio_r == SRD_RATIO_4; endproperty
  a_ratio_by4: assert property (p_ratio_by4) // RULE10
    else $error("Code 00 not divide by four");
  property p_ratio_by2; prediv_r == SRD_PREDIV_BY2 |=> ratio_r == SRD_RATIO_2; endproperty
  a_ratio_by2: assert property (p_ratio_by2) // RULE11
    else $error("Code 01 not divide by two");
  property p_ratio_by1; prediv_r == SRD_PREDIV_BY1 |=> ratio_r == SRD_RATIO_1; endproperty
  a_ratio_by1: assert property (p_ratio_by1) // RULE12
    else $error("Code 10 not undivided");
  property p_term_edge; $rose(term_cal1_r) |=> term_start_r ##1 !term_start_r; endproperty
  a_term_edge: assert property (p_term_edge) // RULE14
    else $error("Termination calibration not a single pulse on edge");

endmodule // srd_pll_regs

// ===== dv/srd_pll_regs_test.sv
// Self-checking bench for the link PLL control registers over the serial port
`timescale 1ns/1ps
module srd_pll_regs_test;
  import srd_pkg::*;

  // ****************************************************************
  // Signals and clock
  // ****************************************************************
  logic             clock;
  logic             reset;
  logic             clk_en;
  logic             spi_sclk;
  logic             spi_cs_n;
  logic             tb_sdio;
  wire logic        sdio_wire;
  logic             spi_sdio_out;
  logic             spi_sdio_oe_n;
  srd_pll_stat_type pll_stat;
  srd_ctrl_type     ctrl;
  int               miscompares;
  int               checked;
  int               cycles;
  int               cal_pulses;
  int               term_pulses;
  int               n;

  // Ordinary cases: write, read back, then equalizer code and ratio
  typedef struct {
    logic [14:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rexp;
    logic [1:0]  eq;
    logic [2:0]  ratio;
  } srd_row_type;

  srd_row_type rows [0:9] = '{
    '{15'h0268, 8'h00, 8'h00, 2'h0, 3'h4},
    '{15'h0268, 8'hFF, 8'hFF, 2'h3, 3'h4},
    '{15'h0268, 8'h44, 8'h44, 2'h1, 3'h4},
    '{15'h0289, 8'hFF, 8'h03, 2'h1, 3'h1},
    '{15'h0289, 8'h02, 8'h02, 2'h1, 3'h1},
    '{15'h0289, 8'h01, 8'h01, 2'h1, 3'h2},
    '{15'h0289, 8'h00, 8'h00, 2'h1, 3'h4},
    '{15'h0280, 8'hFA, 8'h02, 2'h1, 3'h4},
    '{15'h02A7, 8'hFE, 8'h00, 2'h1, 3'h4},
    '{15'h0300, 8'hFF, 8'h00, 2'h1, 3'h4}
  };

  // Status reads of each flag alone: pll_stat value and readback
  logic [3:0]  st_in  [0:3] = '{4'h8, 4'h4, 4'h2, 4'h1};
  logic [7:0]  st_exp [0:3] = '{8'h20, 8'h10, 8'h08, 8'h01};
  logic [14:0] rs_addr [0:4] = '{15'h0268, 15'h0280, 15'h0281, 15'h0289, 15'h02A7};
  logic [7:0]  rs_exp  [0:4] = '{8'h44, 8'h00, 8'h00, 8'h00, 8'h00};

  initial clock = 1'b0;
  always #2 clock = ~clock;

  // Device drives the shared pin only while its enable is low
  assign sdio_wire = (spi_sdio_oe_n === 1'b0) ? spi_sdio_out : tb_sdio;

  srd_pll_regs dut_u (
    .clock         (clock),
    .reset         (reset),
    .clk_en        (clk_en),
    .spi_sclk      (spi_sclk),
    .spi_cs_n      (spi_cs_n),
    .spi_sdio_in   (sdio_wire),
    .spi_sdio_out  (spi_sdio_out),
    .spi_sdio_oe_n (spi_sdio_oe_n),
    .pll_stat      (pll_stat),
    .ctrl          (ctrl)
  );

  // ****************************************************************
  // Pulse counters and hang guard
  // ****************************************************************
  // Pulses last one cycle, so they are counted rather than sampled
  always @(posedge clock)
  begin
    if (ctrl.pll_cal_start === 1'b1)
      cal_pulses++;
    if (ctrl.term_cal_start === 1'b1)
      term_pulses++;
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      summarize();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Mode 0 frame; phases of 8 clocks leave room for the input synchronizers
  task automatic spi_frame(input logic rdn, input logic [14:0] addr,
                           input logic [7:0] wdata, output logic [7:0] rdata);
    logic [23:0] bits;
    int          i;
    bits = {rdn, addr, wdata};
    rdata = 8'h00;
    spi_cs_n = 1'b0;
    tick(8);
    for (i = 23; i >= 0; i--)
    begin
      // A released line does not hold its last value
      if (rdn && i < 8)
        tb_sdio = ~tb_sdio;
      else
        tb_sdio = bits[i];
      tick(8);
      if (rdn && i < 8)
        rdata[i] = sdio_wire;
      spi_sclk = 1'b1;
      tick(8);
      spi_sclk = 1'b0;
    end
    tick(8);
    spi_cs_n = 1'b1;
    tick(10);
  endtask

  task automatic wr(input logic [14:0] addr, input logic [7:0] data);
    logic [7:0] dummy;
    spi_frame(1'b0, addr, data, dummy);
  endtask

  task automatic rd_check(input logic [14:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    spi_frame(1'b1, addr, 8'h00, got);
    check(got, exp);
  endtask

  task automatic summarize();
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    tb_sdio = 1'b0;
    pll_stat = '0;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    cal_pulses = 0;
    term_pulses = 0;
    tick(20);
    check({6'h00, ctrl.equalizer_power_setting}, 8'h01);
    check({5'h00, ctrl.predivide_ratio}, 8'h04);
    check({7'h00, spi_sdio_oe_n}, 8'h01);
    reset = 1'b0;
    tick(5);
    // Table of plain write and readback cases
    for (n = 0; n < 10; n++)
    begin
      wr(rows[n].addr, rows[n].wdata);
      rd_check(rows[n].addr, rows[n].rexp);
      check({6'h00, ctrl.equalizer_power_setting}, {6'h00, rows[n].eq});
      check({5'h00, ctrl.predivide_ratio}, {5'h00, rows[n].ratio});
      check({6'h00, ctrl.reference_predivide_select}, {6'h00, rows[n].rexp[1:0] &
            {2{rows[n].addr == 15'h0289}}} | {6'h00, 2'h0});
    end
    // Each flag alone, read twice so a read cannot clear it
    for (n = 0; n < 4; n++)
    begin
      pll_stat = st_in[n];
      tick(4);
      rd_check(15'h0281, st_exp[n]);
      rd_check(15'h0281, st_exp[n]);
    end
    pll_stat = '0;
    tick(4);
    rd_check(15'h0281, 8'h00);
    // Power-up then recalibrate edges, with a held trigger in between
    cal_pulses = 0;
    wr(15'h0280, 8'h01);
    check({7'h00, ctrl.pll_bias_on}, 8'h01);
    check(cal_pulses[7:0], 8'h01);
    wr(15'h0280, 8'h05);
    check(cal_pulses[7:0], 8'h02);
    wr(15'h0280, 8'h05);
    check(cal_pulses[7:0], 8'h02);
    wr(15'h0280, 8'h01);
    wr(15'h0280, 8'h05);
    check(cal_pulses[7:0], 8'h03);
    wr(15'h0280, 8'h00);
    check({7'h00, ctrl.pll_bias_on}, 8'h00);
    check(cal_pulses[7:0], 8'h03);
    // Termination trigger edges, repeated write must not relaunch
    term_pulses = 0;
    wr(15'h02A7, 8'h01);
    check(term_pulses[7:0], 8'h01);
    wr(15'h02A7, 8'h01);
    check(term_pulses[7:0], 8'h01);
    wr(15'h02A7, 8'h00);
    wr(15'h02A7, 8'h01);
    check(term_pulses[7:0], 8'h02);
    // Frozen clock enable: a whole write frame must leave no trace
    clk_en = 1'b0;
    wr(15'h0268, 8'h80);
    clk_en = 1'b1;
    tick(5);
    rd_check(15'h0268, 8'h44);
    check({6'h00, ctrl.equalizer_power_setting}, 8'h01);
    // Second reset in mid-run returns every register to its reset value
    wr(15'h0268, 8'h00);
    wr(15'h0289, 8'h01);
    reset = 1'b1;
    tick(3);
    reset = 1'b0;
    tick(5);
    for (n = 0; n < 5; n++)
      rd_check(rs_addr[n], rs_exp[n]);
    check({5'h00, ctrl.predivide_ratio}, 8'h04);
    summarize();
  end

endmodule // srd_pll_regs_test
